//--- rtl/acst_defs.svh
`ifndef ACST_DEFS_SVH
`define ACST_DEFS_SVH

// register offsets
`define ACST_OFS_AVG 8'h68
`define ACST_OFS_STATUS 8'h6a
`define ACST_OFS_PIN_CFG 8'h6b
`define ACST_OFS_SOFT_TRIG 8'h6c

// reset values
`define ACST_RST_AVG 8'h61
`define ACST_RST_PIN_CFG 8'h00
`define ACST_RST_SOFT_TRIG 8'h01

// averaging register fields
`define ACST_AVG_OS_HI 6
`define ACST_AVG_OS_LO 4
`define ACST_AVG_LIN_HI 2
`define ACST_AVG_LIN_LO 0

// status register fields
`define ACST_ST_FG_BIT 0
`define ACST_ST_HALT_BIT 1
`define ACST_ST_CODE_HI 4
`define ACST_ST_CODE_LO 2

// pin configuration fields
`define ACST_PIN_TRIG_BIT 0
`define ACST_PIN_SEL_HI 2
`define ACST_PIN_SEL_LO 1

// writable masks: reserved bits never store
`define ACST_MASK_AVG 8'h77
`define ACST_MASK_PIN_CFG 8'h07
`define ACST_MASK_SOFT_TRIG 8'h01

`endif

//--- rtl/acst_pkg.sv
package acst_pkg;

  typedef enum logic [1:0] {
    ACST_SEL_FOREGROUND_COMPLETE_FLAG = 2'b00,
    ACST_SEL_HALTED = 2'b01,
    ACST_SEL_ALARM = 2'b10,
    ACST_SEL_LOW = 2'b11
  } acst_stat_sel_e;

  typedef enum logic [1:0] {
    ACST_PH_RESET = 2'b00,
    ACST_PH_FOREGROUND = 2'b01,
    ACST_PH_BACKGROUND = 2'b10,
    ACST_PH_HALTED = 2'b11
  } acst_phase_e;

  typedef struct packed {
    acst_phase_e phase;
    logic foreground_complete_flag;
    logic halted;
  } acst_trk_s;

  typedef struct packed {
    logic [7:0] avg;
    logic [7:0] pin_cfg;
    logic [7:0] soft_trig;
    logic [7:0] rdata;
    logic stat_pin;
    logic trig;
    logic wake;
  } acst_top_s;

endpackage

//--- rtl/acst_stat_if.sv
`timescale 1ns/10ps
`default_nettype none
interface acst_stat_if;
  logic cal_run;
  logic fg_finish;
  logic fg_skip;
  logic bg_enable;
  logic bg_stop_ack;
  logic bg_resume;
  logic foreground_complete_flag;
  logic halted;

  modport tracker (
    input cal_run, fg_finish, fg_skip, bg_enable, bg_stop_ack, bg_resume,
    output foreground_complete_flag, halted
  );
  modport owner (
    output cal_run, fg_finish, fg_skip, bg_enable, bg_stop_ack, bg_resume,
    input foreground_complete_flag, halted
  );
endinterface
`default_nettype wire

//--- rtl/acst_status_track.sv
`timescale 1ns/10ps
`default_nettype none
module acst_status_track (
  // clock and synchronised reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // calibration events and flags
  acst_stat_if.tracker st
);

  acst_pkg::acst_trk_s trk_ff;
  acst_pkg::acst_trk_s nxt_trk;

  always_comb begin
    nxt_trk = trk_ff;
    if (!st.cal_run) begin
      // calibration held in reset clears the progress flags
      nxt_trk.phase = acst_pkg::ACST_PH_RESET;
      nxt_trk.foreground_complete_flag = 1'b0;
    end else begin
      unique case (trk_ff.phase)
        acst_pkg::ACST_PH_RESET: begin
          nxt_trk.phase = acst_pkg::ACST_PH_FOREGROUND;
        end
        acst_pkg::ACST_PH_FOREGROUND: begin
          if (st.fg_finish || st.fg_skip) begin
            nxt_trk.foreground_complete_flag = 1'b1;
            if (st.bg_enable) begin
              nxt_trk.phase = acst_pkg::ACST_PH_BACKGROUND;
            end else begin
              nxt_trk.phase = acst_pkg::ACST_PH_HALTED;
            end
          end
        end
        acst_pkg::ACST_PH_BACKGROUND: begin
          if (st.bg_stop_ack) begin
            nxt_trk.phase = acst_pkg::ACST_PH_HALTED;
          end
        end
        acst_pkg::ACST_PH_HALTED: begin
          // without background calibration there is nothing to resume
          if (st.bg_resume && st.bg_enable) begin
            nxt_trk.phase = acst_pkg::ACST_PH_BACKGROUND;
          end
        end
      endcase
    end
    nxt_trk.halted = (nxt_trk.phase == acst_pkg::ACST_PH_HALTED);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      trk_ff <= '0;
    end else begin
      trk_ff <= nxt_trk;
    end
  end

  assign st.foreground_complete_flag = trk_ff.foreground_complete_flag;
  assign st.halted = trk_ff.halted;

endmodule
`default_nettype wire

//--- rtl/acst_top.sv
// Summary of operation
// - offset averaging field, bits 6:4, sets offset routine averaging depth
// - linearity averaging field, bits 2:0, sets linearity averaging depth
// - status register is read-only; power-up content not to be relied on
// - halted flag reads 1 once background calibration stops at request
// - halted flag returns to 0 as soon as calibration resumes
// - without background calibration, halted sets on foreground finish or skip
// - foreground-complete flag high after foreground finishes or is skipped
// - status pin select 0 gives foreground-complete, 1 gives halted
// - status pin select 2 gives alarm, 3 holds the pin low
// - trigger source 0 uses software trigger bit, ignores trigger pin
// - trigger source 1 uses trigger pin, ignores software trigger bit
// - pin configuration register resets to all zero
// - software trigger bit stands in for the pin, resets to 1
// - in triggered low-power mode cores wake while selected trigger is low
`timescale 1ns/10ps
`default_nettype none
`include "acst_defs.svh"
module acst_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register access port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // calibration engine
  input wire logic cal_run,
  input wire logic fg_finish,
  input wire logic fg_skip,
  input wire logic bg_enable,
  input wire logic bg_stop_ack,
  input wire logic bg_resume,
  input wire logic [2:0] cal_stat_code,
  input wire logic alarm,
  output logic [2:0] offset_avg_depth,
  output logic [2:0] linearity_avg_depth,
  // pins and low-power control
  input wire logic trigger_input_pin,
  input wire logic lowpower_triggered_wake,
  output logic status_output_pin,
  output logic cal_trigger,
  output logic core_wake
);

  logic [1:0] rst_sync_ff;
  logic rst_sync_n;
  acst_pkg::acst_top_s top_ff;
  acst_pkg::acst_top_s nxt_top;
  logic [7:0] status_word;
  acst_stat_if st_if ();

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_ff[1];

  assign st_if.cal_run = cal_run;
  assign st_if.fg_finish = fg_finish;
  assign st_if.fg_skip = fg_skip;
  assign st_if.bg_enable = bg_enable;
  assign st_if.bg_stop_ack = bg_stop_ack;
  assign st_if.bg_resume = bg_resume;

  acst_status_track u_track (
    .sys_clk(sys_clk),
    .rst_n(rst_sync_n),
    .st(st_if.tracker)
  );

  // live view of engine state; nothing here is software-writable
  always_comb begin
    status_word = 8'h00;
    status_word[`ACST_ST_CODE_HI:`ACST_ST_CODE_LO] = cal_stat_code;
    status_word[`ACST_ST_HALT_BIT] = st_if.halted;
    status_word[`ACST_ST_FG_BIT] = st_if.foreground_complete_flag;
  end

  always_comb begin
    nxt_top = top_ff;
    if (reg_wr) begin
      unique case (reg_addr)
        `ACST_OFS_AVG: nxt_top.avg = reg_wdata & `ACST_MASK_AVG;
        `ACST_OFS_PIN_CFG: begin
          nxt_top.pin_cfg = reg_wdata & `ACST_MASK_PIN_CFG;
        end
        `ACST_OFS_SOFT_TRIG: begin
          nxt_top.soft_trig = reg_wdata & `ACST_MASK_SOFT_TRIG;
        end
        default: ; // status writes are dropped
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `ACST_OFS_AVG: nxt_top.rdata = top_ff.avg;
        `ACST_OFS_STATUS: nxt_top.rdata = status_word;
        `ACST_OFS_PIN_CFG: nxt_top.rdata = top_ff.pin_cfg;
        `ACST_OFS_SOFT_TRIG: nxt_top.rdata = top_ff.soft_trig;
        default: nxt_top.rdata = 8'h00;
      endcase
    end
    unique case (acst_pkg::acst_stat_sel_e'(
        top_ff.pin_cfg[`ACST_PIN_SEL_HI:`ACST_PIN_SEL_LO]))
      acst_pkg::ACST_SEL_FOREGROUND_COMPLETE_FLAG: nxt_top.stat_pin = st_if.foreground_complete_flag;
      acst_pkg::ACST_SEL_HALTED: nxt_top.stat_pin = st_if.halted;
      acst_pkg::ACST_SEL_ALARM: nxt_top.stat_pin = alarm;
      acst_pkg::ACST_SEL_LOW: nxt_top.stat_pin = 1'b0;
    endcase
    if (top_ff.pin_cfg[`ACST_PIN_TRIG_BIT]) begin
      nxt_top.trig = trigger_input_pin;
    end else begin
      nxt_top.trig = top_ff.soft_trig[0];
    end
    // a low trigger wakes sleeping cores only in triggered mode
    nxt_top.wake = lowpower_triggered_wake && !nxt_top.trig;
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      top_ff.avg <= `ACST_RST_AVG;
      top_ff.pin_cfg <= `ACST_RST_PIN_CFG;
      top_ff.soft_trig <= `ACST_RST_SOFT_TRIG;
      top_ff.rdata <= 8'h00;
      top_ff.stat_pin <= 1'b0;
      top_ff.trig <= 1'b1;
      top_ff.wake <= 1'b0;
    end else begin
      top_ff <= nxt_top;
    end
  end

  assign reg_rdata = top_ff.rdata;
  assign offset_avg_depth =
    top_ff.avg[`ACST_AVG_OS_HI:`ACST_AVG_OS_LO];
  assign linearity_avg_depth =
    top_ff.avg[`ACST_AVG_LIN_HI:`ACST_AVG_LIN_LO];
  assign status_output_pin = top_ff.stat_pin;
  assign cal_trigger = top_ff.trig;
  assign core_wake = top_ff.wake;

endmodule
`default_nettype wire

//--- verif/acst_board_model.sv
`timescale 1ns/10ps
`default_nettype none
module acst_board_model (
  // clock and hold request
  input wire logic sys_clk,
  input wire logic frz,
  // board pins
  output logic trigger_input_pin,
  output logic alarm
);
  integer seed = 94572;
  logic hold_ff = 1'b0;
  always @(posedge sys_clk) hold_ff <= frz;
  // pins wander so the selected source truly matters; one process drives them
  initial begin
    {trigger_input_pin, alarm} = 2'h3;
    forever begin
      @(negedge sys_clk);
      if (!hold_ff) {trigger_input_pin, alarm} <= 2'($random(seed));
    end
  end
endmodule
`default_nettype wire

//--- verif/acst_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module acst_top_sva (
  // watched ports
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic cal_run,
  input wire logic [2:0] cal_stat_code,
  input wire logic [2:0] offset_avg_depth,
  input wire logic [2:0] linearity_avg_depth,
  input wire logic lowpower_triggered_wake,
  input wire logic cal_trigger,
  input wire logic core_wake
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic rd_st, rd_pin, rd_avg, rd_none;
  assign rd_st = reg_rd && reg_addr == 8'h6a;
  assign rd_pin = reg_rd && reg_addr == 8'h6b;
  assign rd_avg = reg_rd && reg_addr == 8'h68 && !reg_wr;
  assign rd_none = reg_rd && !(reg_addr inside {8'h68, 8'h6a, 8'h6b, 8'h6c});
  wake_follow_a: assert property (
    core_wake == ($past(lowpower_triggered_wake) && !cal_trigger))
    else $error("wake output does not follow trigger");
  unmapped_zero_a: assert property (rd_none |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  status_code_a: assert property (
    rd_st |=> reg_rdata[4:2] == $past(cal_stat_code))
    else $error("status code field wrong");
  status_rsvd_a: assert property (rd_st |=> reg_rdata[7:5] == 3'h0)
    else $error("status reserved bits set");
  flags_clear_a: assert property (
    !cal_run ##1 (rd_st && !cal_run) |=> reg_rdata[1:0] == 2'h0)
    else $error("flags set while idle");
  avg_fields_a: assert property (rd_avg |=> reg_rdata ==
    {1'b0, offset_avg_depth, 1'b0, linearity_avg_depth})
    else $error("averaging outputs differ from register");
  pin_rsvd_a: assert property (rd_pin |=> reg_rdata[7:3] == 5'h0)
    else $error("pin config reserved bits set");
  read_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  cover property (rd_st ##1 reg_rdata[1:0] == 2'h3);
  cover property (core_wake);
  cover property (rd_avg);
endmodule
bind acst_top acst_top_sva chk_u (.*);
`default_nettype wire

//--- verif/tb_adc_calibration_status_trigger.sv
`timescale 1ns/10ps
`default_nettype none
module tb_adc_calibration_status_trigger;
  logic sys_clk, rst_n, reg_wr, reg_rd, cal_run, bg_enable, frz, te, se;
  logic fg_finish, fg_skip, bg_stop_ack, bg_resume, lowpower_triggered_wake;
  logic trigger_input_pin, alarm, status_output_pin, cal_trigger, core_wake;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [2:0] cal_stat_code, offset_avg_depth, linearity_avg_depth;
  logic [7:0] m_avg = 8'h61, m_pin = 8'h00, m_soft = 8'h01;
  logic fg = 1'b0, hlt = 1'b0;
  logic [7:0] amap [5] = '{8'h68, 8'h6a, 8'h6b, 8'h6c, 8'h55};
  integer failures = 0, compares = 0, seed = 94572, i;
  acst_top dut_u (.*);
  acst_board_model board_u (.*);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] ad, input logic [7:0] dt);
    @(negedge sys_clk);
    reg_addr = ad;
    reg_wdata = dt;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    if (ad == 8'h68) m_avg = dt & 8'h77;
    if (ad == 8'h6b) m_pin = dt & 8'h07;
    if (ad == 8'h6c) m_soft = dt & 8'h01;
  endtask
  task rdc(input logic [7:0] ad);
    logic [7:0] e;
    @(negedge sys_clk);
    reg_addr = ad;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    case (ad)
      8'h68: e = m_avg;
      8'h6a: e = {3'h0, cal_stat_code, hlt, fg};
      8'h6b: e = m_pin;
      8'h6c: e = m_soft;
      default: e = 8'h00;
    endcase
    chk(reg_rdata, e);
  endtask
  task ev(input logic [3:0] v);
    @(negedge sys_clk);
    {fg_finish, fg_skip, bg_stop_ack, bg_resume} = v;
    @(negedge sys_clk);
    {fg_finish, fg_skip, bg_stop_ack, bg_resume} = 4'h0;
  endtask
  task give_verdict;
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    give_verdict;
  end
  initial begin
    {reg_wr, reg_rd, cal_run, bg_enable, frz} = 5'h0;
    {fg_finish, fg_skip, bg_stop_ack, bg_resume} = 4'h0;
    lowpower_triggered_wake = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    cal_stat_code = 3'($random(seed));
    rst_n = 1'b0;
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    for (i = 0; i < 5; i++) rdc(amap[i]);
    chk(8'(cal_trigger), 8'h01);
    chk(8'(status_output_pin), 8'h00);
    chk(8'(core_wake), 8'h00);
    for (i = 0; i < 20; i++) begin
      d = 8'($random(seed));
      wr(amap[i % 5], d);
      rdc(amap[i % 5]);
    end
    chk({1'b0, offset_avg_depth, 1'b0, linearity_avg_depth}, m_avg);
    cal_run = 1'b1;
    ev(4'h8);
    {fg, hlt} = 2'h3;
    rdc(8'h6a);
    cal_run = 1'b0;
    @(negedge sys_clk);
    {cal_run, bg_enable, fg, hlt} = 4'hc;
    ev(4'h4);
    fg = 1'b1;
    rdc(8'h6a);
    ev(4'h2);
    hlt = 1'b1;
    rdc(8'h6a);
    ev(4'h1);
    hlt = 1'b0;
    rdc(8'h6a);
    for (i = 0; i < 16; i++) begin
      frz = 1'b1;
      lowpower_triggered_wake = 1'($random(seed));
      d = 8'($random(seed));
      wr(8'h6c, d);
      wr(8'h6b, {d[7:3], i[2:0]});
      repeat (3) @(negedge sys_clk);
      te = m_pin[0] ? trigger_input_pin : m_soft[0];
      case (m_pin[2:1])
        2'h0: se = fg;
        2'h1: se = hlt;
        2'h2: se = alarm;
        default: se = 1'b0;
      endcase
      chk(8'(cal_trigger), 8'(te));
      chk(8'(core_wake), 8'(lowpower_triggered_wake & ~te));
      chk(8'(status_output_pin), 8'(se));
      frz = 1'b0;
      @(negedge sys_clk);
    end
    give_verdict;
  end
endmodule
`default_nettype wire
